// >>> jls_link_shell.sv
/*
  Converter link shell: transmit and receive link layer with APB register port.
  Assumes one clock for link and registers, a PHY doing 8B/10B, alignment and
  serialisation, and transport logic that supplies a word every cycle.
*/
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none

module jls_link_shell (
  input  wire logic                                       I_CLK,
  input  wire logic                                       I_RESET,
  input  wire logic                                       I_PSEL,
  input  wire logic                                       I_PENABLE,
  input  wire logic                                       I_PWRITE,
  input  wire logic [jls_pkg::ADDR_W-1:0]                 I_PADDR,
  input  wire logic [31:0]                                I_PWDATA,
  output logic      [31:0]                                O_PRDATA,
  output logic                                            O_PREADY,
  output logic                                            O_PSLVERR,
  input  wire logic                                       I_SYSREF,
  input  wire logic                                       I_SYNC_N,
  output logic                                            O_SYNC_N,
  input  wire logic [jls_pkg::LANES*jls_pkg::WORD_W-1:0]  I_TX_DATA,
  output logic                                            O_TX_LINK_READY,
  output logic      [jls_pkg::LANES*jls_pkg::WORD_W-1:0]  O_TX_LANE_DATA,
  output logic      [jls_pkg::LANES*jls_pkg::OCT_N-1:0]   O_TX_LANE_K,
  input  wire logic [jls_pkg::LANES*jls_pkg::WORD_W-1:0]  I_RX_LANE_DATA,
  input  wire logic [jls_pkg::LANES*jls_pkg::OCT_N-1:0]   I_RX_LANE_K,
  output logic      [jls_pkg::LANES*jls_pkg::WORD_W-1:0]  O_RX_DATA,
  output logic                                            O_RX_VALID
);
  import jls_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  jls_state_type                  state_reg;
  jls_state_type                  state_next;
  logic [LANES-1:0][46:0]         tx_scr_res;
  logic [LANES-1:0][46:0]         rx_scr_res;
  logic [LANES-1:0]               rx_lane_k_all;
  logic                           rx_all_k;
  logic                           addr_hit;
  logic [31:0]                    rd_mux;
  logic [31:0]                    status_word;
  logic                           sysref_edge;
  logic                           sync_n_in;
  logic [15:0]                    mf_prod;
  logic [MF_W-1:0]                mf_last;
  logic                           lmfc_wrap;
  logic [CFG0_F_W-1:0]            f_m1;
  logic [CFG0_K_W-1:0]            k_m1;
  logic [RBD_W-1:0]               rbd_value;
  logic [RBD_W-1:0]               adj_value;

  // ****************************************************************
  // Self-synchronous scrambler, 1 + x^14 + x^15, first octet first
  // ****************************************************************
  function automatic logic [46:0] scr_word(input logic [31:0] din,
                                           input logic [14:0] st,
                                           input logic        descr);
    logic [14:0] s;
    logic [31:0] q;
    logic        b;
    s = st;
    q = '0;
    for (int i = 31; i >= 0; i--) begin
      b    = din[i] ^ s[13] ^ s[14];
      q[i] = b;
      s    = {s[13:0], (descr ? din[i] : b)};
    end
    return {s, q};
  endfunction

  // ****************************************************************
  // Per-lane scrambling and comma detection
  // ****************************************************************
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign tx_scr_res[g]    = scr_word(I_TX_DATA[g*WORD_W +: WORD_W],
                                       state_reg.tx_scr[g], 1'b0);
    assign rx_scr_res[g]    = scr_word(I_RX_LANE_DATA[g*WORD_W +: WORD_W],
                                       state_reg.rx_scr[g], 1'b1);
    assign rx_lane_k_all[g] = (I_RX_LANE_DATA[g*WORD_W +: WORD_W] == {OCT_N{K28_5}})
                              && (I_RX_LANE_K[g*OCT_N +: OCT_N] == {OCT_N{1'b1}});
  end
  assign rx_all_k = &rx_lane_k_all;

  // ****************************************************************
  // Shadowed configuration and multiframe length
  // ****************************************************************
  assign f_m1      = state_reg.sh_cfg0[CFG0_F_LSB +: CFG0_F_W];
  assign k_m1      = state_reg.sh_cfg0[CFG0_K_LSB +: CFG0_K_W];
  assign rbd_value = state_reg.sh_delay[DLY_RBD_LSB +: RBD_W];
  assign adj_value = state_reg.sh_delay[DLY_ADJ_LSB +: RBD_W];
  assign mf_prod   = ({8'h00, f_m1} + 16'h0001) * ({11'h000, k_m1} + 16'h0001);
  assign mf_last   = (mf_prod[15:2] == 14'h0000) ? '0 : MF_W'(mf_prod[15:2] - 14'h0001);
  assign lmfc_wrap = (state_reg.lmfc_count >= mf_last);

  // ****************************************************************
  // Synchronised pins
  // ****************************************************************
  assign sysref_edge = state_reg.sysref_sync[1] & ~state_reg.sysref_sync[2];
  assign sync_n_in   = state_reg.syncn_sync[1];

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  always_comb begin
    status_word = '0;
    status_word[ST_TX_LSB +: 3]     = state_reg.tx_state;
    status_word[ST_RX_LSB +: 5]     = state_reg.rx_state;
    status_word[ST_SYSREF]          = state_reg.sysref_seen;
    status_word[ST_TX_RDY]          = state_reg.tx_ready;
    status_word[ST_RX_VLD]          = state_reg.rx_valid;
    status_word[ST_LMFC_LSB +: MF_W] = state_reg.lmfc_count;
    addr_hit = 1'b1;
    unique case (I_PADDR)
      OFS_CTRL:   rd_mux = state_reg.ctrl;
      OFS_CFG0:   rd_mux = state_reg.cfg0;
      OFS_CFG1:   rd_mux = state_reg.cfg1;
      OFS_DELAY:  rd_mux = state_reg.delay;
      OFS_STATUS: rd_mux = status_word;
      default: begin
        rd_mux   = '0;
        addr_hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;

    // APB slave
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    if (I_PSEL && !I_PENABLE && I_PWRITE) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = ~addr_hit;
    end
    if (I_PSEL && I_PENABLE && !I_PWRITE && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = ~addr_hit;
      state_next.prdata  = rd_mux;
    end
    if (I_PSEL && I_PENABLE && I_PWRITE && state_reg.pready) begin
      unique case (I_PADDR)
        OFS_CTRL:  state_next.ctrl  = I_PWDATA & CTRL_MASK;
        OFS_CFG0:  state_next.cfg0  = I_PWDATA & CFG0_MASK;
        OFS_CFG1:  state_next.cfg1  = I_PWDATA & CFG1_MASK;
        OFS_DELAY: state_next.delay = I_PWDATA & DELAY_MASK;
        default: begin
        end
      endcase
    end

    // Configuration shadow, loaded only while both links are held in reset
    if (!state_reg.ctrl[CTRL_TX_EN] && !state_reg.ctrl[CTRL_RX_EN]) begin
      state_next.sh_cfg0  = state_reg.cfg0;
      state_next.sh_delay = state_reg.delay;
      state_next.sh_scr   = state_reg.ctrl[CTRL_SCR_EN];
    end

    // Pin synchronisers
    state_next.sysref_sync = {state_reg.sysref_sync[1:0], I_SYSREF};
    state_next.syncn_sync  = {state_reg.syncn_sync[0], I_SYNC_N};

    // Multiframe counter with delayed SYSREF alignment
    state_next.lmfc_count = lmfc_wrap ? '0 : state_reg.lmfc_count + MF_W'(1);
    if (state_reg.adj_count != '0) begin
      state_next.adj_count = state_reg.adj_count - RBD_W'(1);
      if (state_reg.adj_count == RBD_W'(1)) begin
        state_next.lmfc_count = '0;
      end
    end
    if (sysref_edge) begin
      state_next.sysref_seen = 1'b1;
      if (adj_value == '0) begin
        state_next.lmfc_count = '0;
      end else begin
        state_next.adj_count = adj_value;
      end
    end

    // Transmit link
    state_next.tx_ready     = 1'b0;
    state_next.tx_lane_k    = '0;
    state_next.tx_lane_data = '0;
    unique case (state_reg.tx_state)
      TX_RESET: begin
        if (state_reg.ctrl[CTRL_TX_EN]) begin
          state_next.tx_state = TX_CGS;
        end
      end
      TX_CGS: begin
        state_next.tx_lane_data = {(LANES*OCT_N){K28_5}};
        state_next.tx_lane_k    = '1;
        if (sync_n_in && lmfc_wrap) begin
          state_next.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        state_next.tx_ready = 1'b1;
        for (int l = 0; l < LANES; l++) begin
          if (state_reg.sh_scr) begin
            state_next.tx_lane_data[l*WORD_W +: WORD_W] = tx_scr_res[l][31:0];
            state_next.tx_scr[l] = tx_scr_res[l][46:32];
          end else begin
            state_next.tx_lane_data[l*WORD_W +: WORD_W] = I_TX_DATA[l*WORD_W +: WORD_W];
          end
        end
        if (!sync_n_in) begin
          state_next.tx_state = TX_CGS;
          state_next.tx_ready = 1'b0;
        end
      end
    endcase
    if (!state_reg.ctrl[CTRL_TX_EN]) begin
      state_next.tx_state     = TX_RESET;
      state_next.tx_ready     = 1'b0;
      state_next.tx_lane_k    = '0;
      state_next.tx_lane_data = '0;
      state_next.tx_scr       = '0;
    end

    // Receive link
    state_next.rx_valid = 1'b0;
    unique case (state_reg.rx_state)
      RX_RESET: begin
        state_next.rx_sync_n = 1'b1;
        state_next.rx_kcount = '0;
        if (state_reg.ctrl[CTRL_RX_EN]) begin
          state_next.rx_state = RX_CGS;
        end
      end
      RX_CGS: begin
        state_next.rx_sync_n = 1'b0;
        if (rx_all_k) begin
          state_next.rx_kcount = state_reg.rx_kcount + 3'h1;
          if (state_reg.rx_kcount == RX_K_NEEDED - 3'h1) begin
            state_next.rx_state  = RX_ALIGN;
            state_next.rx_sync_n = 1'b1;
          end
        end else begin
          state_next.rx_kcount = '0;
        end
      end
      RX_ALIGN: begin
        if (lmfc_wrap) begin
          state_next.rbd_count = '0;
          state_next.rx_state  = RX_DELAY;
        end
      end
      RX_DELAY: begin
        if (state_reg.rbd_count >= rbd_value) begin
          state_next.rx_state = RX_DATA;
        end else begin
          state_next.rbd_count = state_reg.rbd_count + RBD_W'(1);
        end
      end
      RX_DATA: begin
        state_next.rx_valid = 1'b1;
        for (int l = 0; l < LANES; l++) begin
          if (state_reg.sh_scr) begin
            state_next.rx_data[l*WORD_W +: WORD_W] = rx_scr_res[l][31:0];
            state_next.rx_scr[l] = rx_scr_res[l][46:32];
          end else begin
            state_next.rx_data[l*WORD_W +: WORD_W] = I_RX_LANE_DATA[l*WORD_W +: WORD_W];
          end
        end
        if (rx_all_k) begin
          state_next.rx_state  = RX_CGS;
          state_next.rx_valid  = 1'b0;
          state_next.rx_kcount = 3'h1;
        end
      end
    endcase
    if (!state_reg.ctrl[CTRL_RX_EN]) begin
      state_next.rx_state  = RX_RESET;
      state_next.rx_valid  = 1'b0;
      state_next.rx_sync_n = 1'b1;
      state_next.rx_scr    = '0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg             <= '0;
      state_reg.ctrl        <= CTRL_RST;
      state_reg.cfg0        <= CFG0_RST;
      state_reg.cfg1        <= CFG1_RST;
      state_reg.delay       <= DELAY_RST;
      state_reg.sh_cfg0     <= CFG0_RST;
      state_reg.sh_delay    <= DELAY_RST;
      state_reg.syncn_sync  <= 2'h3;
      state_reg.tx_state    <= TX_RESET;
      state_reg.rx_state    <= RX_RESET;
      state_reg.rx_sync_n   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_PRDATA        = state_reg.prdata;
  assign O_PREADY        = state_reg.pready;
  assign O_PSLVERR       = state_reg.pslverr;
  assign O_SYNC_N        = state_reg.rx_sync_n;
  assign O_TX_LINK_READY = state_reg.tx_ready;
  assign O_TX_LANE_DATA  = state_reg.tx_lane_data;
  assign O_TX_LANE_K     = state_reg.tx_lane_k;
  assign O_RX_DATA       = state_reg.rx_data;
  assign O_RX_VALID      = state_reg.rx_valid;

endmodule

`default_nettype wire

// >>> jls_pkg.sv
/*
  Constants, register map and state types of the converter link shell.
  Assumes a single 10 MHz clock that serves as link clock and register clock.
*/
`default_nettype none

package jls_pkg;

  // ****************************************************************
  // Datapath shape
  // ****************************************************************
  localparam int LANES  = 2;
  localparam int WORD_W = 32;
  localparam int OCT_N  = 4;
  localparam int ADDR_W = 8;
  localparam int MF_W   = 12;
  localparam int RBD_W  = 10;
  localparam int SCR_W  = 15;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [2:0] RX_K_NEEDED = 3'h4;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG0   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG1   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DELAY  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ****************************************************************
  // Field positions and masks
  // ****************************************************************
  localparam int CTRL_TX_EN  = 0;
  localparam int CTRL_RX_EN  = 1;
  localparam int CTRL_SCR_EN = 2;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0007;
  localparam int CFG0_F_LSB  = 0;
  localparam int CFG0_F_W    = 8;
  localparam int CFG0_K_LSB  = 8;
  localparam int CFG0_K_W    = 5;
  localparam logic [31:0] CFG0_MASK  = 32'hFF1F_1FFF;
  localparam logic [31:0] CFG1_MASK  = 32'h101F_1F1F;
  localparam int DLY_RBD_LSB = 0;
  localparam int DLY_ADJ_LSB = 16;
  localparam logic [31:0] DELAY_MASK = 32'h03FF_03FF;
  localparam int ST_TX_LSB   = 0;
  localparam int ST_RX_LSB   = 4;
  localparam int ST_SYSREF   = 9;
  localparam int ST_TX_RDY   = 10;
  localparam int ST_RX_VLD   = 11;
  localparam int ST_LMFC_LSB = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] CFG0_RST  = 32'h0101_1F01;
  localparam logic [31:0] CFG1_RST  = 32'h0000_0F0F;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    TX_RESET = 3'h1,
    TX_CGS   = 3'h2,
    TX_DATA  = 3'h4
  } jls_tx_state_type;

  typedef enum logic [4:0] {
    RX_RESET = 5'h01,
    RX_CGS   = 5'h02,
    RX_ALIGN = 5'h04,
    RX_DELAY = 5'h08,
    RX_DATA  = 5'h10
  } jls_rx_state_type;

  typedef struct packed {
    logic [31:0]                       ctrl;
    logic [31:0]                       cfg0;
    logic [31:0]                       cfg1;
    logic [31:0]                       delay;
    logic [31:0]                       sh_cfg0;
    logic [31:0]                       sh_delay;
    logic                              sh_scr;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    logic [2:0]                        sysref_sync;
    logic [1:0]                        syncn_sync;
    logic                              sysref_seen;
    logic [MF_W-1:0]                   lmfc_count;
    logic [RBD_W-1:0]                  rbd_count;
    logic [RBD_W-1:0]                  adj_count;
    jls_tx_state_type                  tx_state;
    jls_rx_state_type                  rx_state;
    logic [2:0]                        rx_kcount;
    logic [LANES-1:0][SCR_W-1:0]       tx_scr;
    logic [LANES-1:0][SCR_W-1:0]       rx_scr;
    logic [LANES*WORD_W-1:0]           tx_lane_data;
    logic [LANES*OCT_N-1:0]            tx_lane_k;
    logic                              tx_ready;
    logic [LANES*WORD_W-1:0]           rx_data;
    logic                              rx_valid;
    logic                              rx_sync_n;
  } jls_state_type;

endpackage

`default_nettype wire

// >>> jls_link_shell_asserts.sv
/*
  Concurrent checks on the ports of the converter link shell.
  Assumes the shell's package is compiled first; bound to every shell instance.
*/
`default_nettype none

module jls_link_shell_asserts (
  input wire logic                        I_CLK,
  input wire logic                        I_RESET,
  input wire logic                        I_PSEL,
  input wire logic                        I_PENABLE,
  input wire logic                        I_PWRITE,
  input wire logic [jls_pkg::ADDR_W-1:0]  I_PADDR,
  input wire logic [31:0]                 O_PRDATA,
  input wire logic                        O_PREADY,
  input wire logic                        O_PSLVERR,
  input wire logic                        O_SYNC_N,
  input wire logic                        O_TX_LINK_READY,
  input wire logic [7:0]                  O_TX_LANE_K,
  input wire logic                        O_RX_VALID
);
  timeunit 1ns;
  timeprecision 1ns;
  import jls_pkg::*;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  logic mapped;
  assign mapped = I_PADDR inside {OFS_CTRL, OFS_CFG0, OFS_CFG1, OFS_DELAY, OFS_STATUS};

  a_wr_no_wait : assert property (
    I_PSEL && I_PENABLE && I_PWRITE && !$past(I_PENABLE) |-> O_PREADY)
    else $error("write not answered in first access cycle");
  a_rd_one_wait : assert property (
    I_PSEL && I_PENABLE && !I_PWRITE && !$past(I_PENABLE) |-> !O_PREADY ##1 O_PREADY)
    else $error("read not answered after one wait cycle");
  a_ready_one_cycle : assert property (
    O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_on_unmapped : assert property (
    O_PREADY |-> O_PSLVERR == !mapped)
    else $error("error flag does not match address map");
  a_err_read_zero : assert property (
    O_PREADY && O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("refused read returned data");
  a_k_before_data : assert property (
    $rose(O_TX_LINK_READY) |-> $past(O_TX_LANE_K) == 8'hFF)
    else $error("link came up without sync characters");
  a_data_no_k : assert property (
    O_TX_LINK_READY |-> O_TX_LANE_K == 8'h00)
    else $error("control flag set in user data");
  a_valid_no_request : assert property (
    O_RX_VALID |-> O_SYNC_N)
    else $error("receive valid while requesting sync");
  a_valid_after_sync : assert property (
    $rose(O_RX_VALID) |-> $past(O_SYNC_N) && $past(O_SYNC_N, 2))
    else $error("receive valid too soon after sync");

  c_read : cover property (I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY);
  c_err : cover property (O_PREADY && O_PSLVERR);
  c_tx_up : cover property ($rose(O_TX_LINK_READY));
  c_rx_up : cover property ($rose(O_RX_VALID));

endmodule

bind jls_link_shell jls_link_shell_asserts jls_link_shell_asserts_inst (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_SYNC_N(O_SYNC_N), .O_TX_LINK_READY(O_TX_LINK_READY),
  .O_TX_LANE_K(O_TX_LANE_K), .O_RX_VALID(O_RX_VALID));

`default_nettype wire

// >>> jls_far_model.sv
/*
  Far side of the link: a converter receiver and a converter transmitter.
  Assumes the same clock as the shell and two lanes of four octets.
*/
`default_nettype none

module jls_far_model (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [63:0]  i_tx_lane_data,
  input  wire logic [7:0]   i_tx_lane_k,
  input  wire logic         i_rx_sync_n,
  input  wire logic [63:0]  i_payload,
  output logic              o_sync_n,
  output logic      [63:0]  o_rx_lane_data,
  output logic      [7:0]   o_rx_lane_k
);
  timeunit 1ns;
  timeprecision 1ns;
  import jls_pkg::*;

  logic [2:0] kseen_reg;
  logic [4:0] tail_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      kseen_reg      <= 3'h0;
      tail_reg       <= 5'h00;
      o_sync_n       <= 1'b0;
      o_rx_lane_data <= 64'h0;
      o_rx_lane_k    <= 8'h00;
    end else begin
      // Receiver: request held low until four all-K words arrive
      if (i_tx_lane_k == 8'hFF && i_tx_lane_data == {8{K28_5}}) begin
        if (kseen_reg != 3'h4) kseen_reg <= kseen_reg + 3'h1;
      end else if (!o_sync_n) begin
        kseen_reg <= 3'h0;
      end
      if (kseen_reg == 3'h4) o_sync_n <= 1'b1;
      // Transmitter: K while requested and for a tail, then a word every cycle
      tail_reg <= !i_rx_sync_n ? 5'h00 : (tail_reg == 5'h12) ? tail_reg : tail_reg + 5'h01;
      o_rx_lane_data <= (tail_reg == 5'h12) ? i_payload : {8{K28_5}};
      o_rx_lane_k    <= (tail_reg == 5'h12) ? 8'h00 : 8'hFF;
    end
  end

endmodule

`default_nettype wire

// >>> test_converter_link_shell.sv
/*
  Self-checking bench for the converter link shell.
  Assumes the far model stands on the lanes and sync pins.
*/
`default_nettype none

module test_converter_link_shell;
  timeunit 1ns;
  timeprecision 1ns;
  import jls_pkg::*;

  logic        I_CLK = 1'b0, I_RESET = 1'b1, I_PSEL = 1'b0, I_PENABLE = 1'b0;
  logic        I_PWRITE = 1'b0, I_SYSREF = 1'b0, err, far_sync_n;
  logic [7:0]  I_PADDR = 8'h00, O_TX_LANE_K, rx_k;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
  logic [63:0] I_TX_DATA = 64'h0, pld = 64'h0123_4567_89AB_CDEF;
  logic [63:0] O_TX_LANE_DATA, O_RX_DATA, rx_lane;
  logic        O_PREADY, O_PSLVERR, O_SYNC_N, O_TX_LINK_READY, O_RX_VALID;
  int          errors = 0, checks = 0;

  always #50 I_CLK = ~I_CLK;

  jls_link_shell jls_link_shell_inst (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_SYSREF(I_SYSREF), .I_SYNC_N(far_sync_n),
    .O_SYNC_N(O_SYNC_N), .I_TX_DATA(I_TX_DATA), .O_TX_LINK_READY(O_TX_LINK_READY),
    .O_TX_LANE_DATA(O_TX_LANE_DATA), .O_TX_LANE_K(O_TX_LANE_K), .I_RX_LANE_DATA(rx_lane),
    .I_RX_LANE_K(rx_k), .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID));

  jls_far_model jls_far_model_inst (
    .i_clk(I_CLK), .i_reset(I_RESET), .i_tx_lane_data(O_TX_LANE_DATA),
    .i_tx_lane_k(O_TX_LANE_K), .i_rx_sync_n(O_SYNC_N), .i_payload(pld),
    .o_sync_n(far_sync_n), .o_rx_lane_data(rx_lane), .o_rx_lane_k(rx_k));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task give_verdict;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task fail(input string m);
    errors++;
    $display("BAD %0t %s", $time, m);
    give_verdict();
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge I_CLK);
    I_PSEL    <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE  <= wr;
    I_PADDR   <= a;
    I_PWDATA  <= wd;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge I_CLK);
      n++;
    end while (O_PREADY !== 1'b1 && n < 20);
    if (O_PREADY !== 1'b1) fail("no ready");
    rd = O_PRDATA;
    err = O_PSLVERR;
    I_PSEL    <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_regs;
    logic [7:0]  ofs [4];
    logic [31:0] rst [4];
    ofs = '{OFS_CTRL, OFS_CFG0, OFS_CFG1, OFS_DELAY};
    rst = '{CTRL_RST, CFG0_RST, CFG1_RST, DELAY_RST};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      chk({31'h0, err, rd}, {32'h0, rst[i]}, "reset value");
    end
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err, rd}, 64'h1_0000_0000, "unmapped read");
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk({63'h0, err}, 64'h1, "unmapped write");
    apb(1'b1, OFS_CFG0, CFG0_RST);
    apb(1'b1, OFS_DELAY, 32'hFC00_0018);
    apb(1'b0, OFS_DELAY, 32'h0);
    chk({31'h0, err, rd}, 64'h18, "delay readback");
  endtask

  task t_tx_cgs;
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge I_CLK);
    chk({56'h0, O_TX_LANE_K}, 64'hFF, "sync flags");
    chk(O_TX_LANE_DATA, {8{K28_5}}, "sync characters");
    I_SYSREF <= 1'b1;
    repeat (2) @(posedge I_CLK);
    I_SYSREF <= 1'b0;
    repeat (6) @(posedge I_CLK);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({63'h0, rd[ST_SYSREF]}, 64'h1, "alignment seen");
  endtask

  task t_tx_data;
    int n;
    for (n = 0; n < 300 && O_TX_LINK_READY !== 1'b1; n++) @(posedge I_CLK);
    if (O_TX_LINK_READY !== 1'b1) fail("transmit not up");
    I_TX_DATA <= 64'hA5A5_0001_5A5A_0002;
    @(posedge I_CLK);
    I_TX_DATA <= 64'h0F0F_1234_F0F0_5678;
    @(posedge I_CLK);
    chk(O_TX_LANE_DATA, 64'hA5A5_0001_5A5A_0002, "lane word");
    chk({56'h0, O_TX_LANE_K}, 64'h0, "lane flags");
    @(posedge I_CLK);
    chk(O_TX_LANE_DATA, 64'h0F0F_1234_F0F0_5678, "next lane word");
  endtask

  task t_rx;
    int n;
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    for (n = 0; n < 300 && O_RX_VALID !== 1'b1; n++) @(posedge I_CLK);
    if (O_RX_VALID !== 1'b1) fail("receive not valid");
    repeat (3) @(posedge I_CLK);
    chk(O_RX_DATA, pld, "received word");
    chk({63'h0, O_SYNC_N}, 64'h1, "sync released");
  endtask

  task t_off;
    apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    chk({63'h0, err}, 64'h0, "status write");
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge I_CLK);
    chk({54'h0, O_TX_LANE_K, O_TX_LINK_READY, O_RX_VALID}, 64'h0, "link off");
  endtask

  initial begin
    repeat (6) @(posedge I_CLK);
    I_RESET <= 1'b0;
    t_regs();
    t_tx_cgs();
    t_tx_data();
    t_rx();
    t_off();
    give_verdict();
  end

endmodule

`default_nettype wire
